/* File: include/dpr_pkg.sv */
// Shared constants for the dual-port synchronous RAM port logic.
// Assumes every design file refers to these names as dpr_pkg::name.
package dpr_pkg;

  // Array geometry: 256K words of two 9-bit bytes
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned BYTE_W     = 9;
  localparam int unsigned NUM_BYTES  = 2;
  localparam int unsigned NUM_PORTS  = 2;

  // Byte lane positions
  localparam int unsigned LOWER_BYTE = 0;
  localparam int unsigned UPPER_BYTE = 1;

  // Selected cycles needed after a deselect before outputs may drive again
  localparam int unsigned WAKE_W       = 2;
  localparam logic [1:0]  WAKE_CYCLES  = 2'h2;
  localparam logic [1:0]  WAKE_RESET   = 2'h0;
  localparam logic [1:0]  WAKE_STEP    = 2'h1;

  // Reset value of the internal address and the repeat base
  localparam logic [17:0] ADDR_RESET   = 18'h00000;

endpackage : dpr_pkg

/* File: logic/dpr_addr_ctr.sv */
// Address counter of one port: load, advance, hold and repeat.
// Assumes its controls are sampled on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none

module dpr_addr_ctr #(
  parameter int unsigned ADDR_W = dpr_pkg::ADDR_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic              load_n,
  input  wire logic              advance_n,
  input  wire logic              repeat_n,
  output wire logic [ADDR_W-1:0] addr_next,
  output logic      [ADDR_W-1:0] addr_q,
  output logic      [ADDR_W-1:0] base_q
);

  // Refuse widths the reset constant cannot serve
  if (ADDR_W < 1 || ADDR_W > $bits(dpr_pkg::ADDR_RESET)) begin : g_bad_width
    $error("dpr_addr_ctr: ADDR_W out of range");
  end

  wire logic [ADDR_W-1:0] addr_inc;
  wire logic [ADDR_W-1:0] addr_rst;

  assign addr_inc = addr_q + ADDR_W'(1);
  assign addr_rst = dpr_pkg::ADDR_RESET[ADDR_W-1:0];

  // Load beats repeat, repeat beats advance, otherwise hold
  assign addr_next = !load_n    ? ext_addr :
                     !repeat_n  ? base_q :
                     !advance_n ? addr_inc :
                                  addr_q;

  // Internal address and the base kept from the last load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q <= addr_rst;
      base_q <= addr_rst;
    end else if (clk_en) begin
      addr_q <= addr_next;
      if (!load_n) begin
        base_q <= ext_addr;
      end
    end
  end

endmodule : dpr_addr_ctr

`default_nettype wire

/* File: logic/dpr_mem.sv */
// Storage array shared by both ports, byte writes, registered reads.
// Assumes one clock for both ports; read data come out of a register.
`timescale 1ns/10ps
`default_nettype none

module dpr_mem #(
  parameter int unsigned ADDR_W    = dpr_pkg::ADDR_W,
  parameter int unsigned DATA_W    = dpr_pkg::DATA_W,
  parameter int unsigned BYTE_W    = dpr_pkg::BYTE_W,
  parameter int unsigned NUM_BYTES = dpr_pkg::NUM_BYTES,
  parameter int unsigned NUM_PORTS = dpr_pkg::NUM_PORTS
) (
  input  wire logic                                ref_clk,
  input  wire logic                                clk_en,
  input  wire logic [NUM_PORTS-1:0][NUM_BYTES-1:0] wr_en,
  input  wire logic [NUM_PORTS-1:0][ADDR_W-1:0]    wr_addr,
  input  wire logic [NUM_PORTS-1:0][DATA_W-1:0]    wr_data,
  input  wire logic [NUM_PORTS-1:0]                rd_en,
  input  wire logic [NUM_PORTS-1:0][ADDR_W-1:0]    rd_addr,
  output wire logic [NUM_PORTS-1:0][DATA_W-1:0]    rd_data
);

  if (DATA_W != BYTE_W * NUM_BYTES) begin : g_bad_width
    $error("dpr_mem: DATA_W must equal BYTE_W * NUM_BYTES");
  end

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rd_q [NUM_PORTS];

  // Byte writes; on a same-word clash the higher port lands last
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int b = 0; b < NUM_BYTES; b++) begin
          if (wr_en[p][b]) begin
            mem[wr_addr[p]][b*BYTE_W +: BYTE_W] <= wr_data[p][b*BYTE_W +: BYTE_W];
          end
        end
      end
    end
  end

  // Reads see the word before a write landing on the same edge
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rd
    always_ff @(posedge ref_clk) begin
      if (clk_en && rd_en[p]) begin
        rd_q[p] <= mem[rd_addr[p]];
      end
    end
    assign rd_data[p] = rd_q[p];
  end

endmodule : dpr_mem

`default_nettype wire

/* File: logic/dpr_port_top.sv */
// Port logic of a synchronous dual-port RAM: selects, counter, outputs.
// Assumes all inputs but output_enable_n are synchronous to ref_clk and
// that output_latency_select is held steady during operation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Capture address, data, byte enables and controls on the rising clock edge.
// - Output enable switches data drivers asynchronously, without a clock edge.
// - Counter holds its value while load strobe, counter advance and counter repeat are all inactive.
// - Either chip select inactive for a cycle deselects the port into standby.
// - After deselect, outputs drive only after two consecutive selected cycles.
// - Output drive state follows the controls sampled one cycle earlier in flow-through, two cycles earlier in pipelined.
// - Address load strobe low loads the external address on every edge.
// - Access uses external address while strobe low, counter output otherwise.
// - Counter advance low increments the address and accesses the new one.
// - Strobe, advance and repeat all high keep the address; read data stay constant.
// - Counter reload takes no idle cycle; access happens in the same cycle.
// - Reload returns the address to the one captured by the last load.
// - A write shows on the other port one reading cycle later if clocks align.
// - Two chip selects of opposite polarity allow banking without decode.
// - Both ports have identical timing and behaviour.
// - Latency select high gives pipelined, low gives flow-through output.
// - Byte enable high on a read leaves that output byte undriven.
module dpr_port_top #(
  parameter int unsigned ADDR_W = dpr_pkg::ADDR_W,
  parameter int unsigned DATA_W = dpr_pkg::DATA_W
) (
  input  wire logic                                        ref_clk,
  input  wire logic                                        rst,
  input  wire logic                                        clk_en,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               chip_select_a_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               chip_select_b,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               address_load_strobe_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               counter_advance_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               counter_repeat_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               upper_byte_enable_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               lower_byte_enable_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               read_not_write,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               output_enable_n,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0]               output_latency_select,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0][ADDR_W-1:0]   address,
  input  wire logic [dpr_pkg::NUM_PORTS-1:0][DATA_W-1:0]   data_in,
  output wire logic [dpr_pkg::NUM_PORTS-1:0][DATA_W-1:0]   data_out,
  output wire logic [dpr_pkg::NUM_PORTS-1:0][dpr_pkg::NUM_BYTES-1:0] data_oe_n,
  output wire logic [dpr_pkg::NUM_PORTS-1:0]               port_standby
);

  localparam int unsigned NP = dpr_pkg::NUM_PORTS;
  localparam int unsigned NB = dpr_pkg::NUM_BYTES;
  localparam int unsigned BW = dpr_pkg::BYTE_W;
  localparam int unsigned LB = dpr_pkg::LOWER_BYTE;
  localparam int unsigned UB = dpr_pkg::UPPER_BYTE;

  // Refuse geometries the byte lanes cannot serve
  if (DATA_W != BW * NB || ADDR_W > dpr_pkg::ADDR_W) begin : g_bad_param
    $error("dpr_port_top: DATA_W or ADDR_W not supported");
  end

  // Memory side wiring
  wire [NP-1:0][NB-1:0]     mem_we;
  wire [NP-1:0][ADDR_W-1:0] mem_waddr;
  wire [NP-1:0][DATA_W-1:0] mem_wdata;
  wire [NP-1:0]             mem_re;
  wire [NP-1:0][ADDR_W-1:0] mem_raddr;
  wire [NP-1:0][DATA_W-1:0] mem_rdata;

  // Per-port combinational terms and counter outputs
  logic              sel_raw   [NP];
  logic [NB-1:0]     be_raw_n  [NP];
  logic [1:0]        wake_d    [NP];
  logic [NB-1:0]     drv_ft_d  [NP];
  logic [ADDR_W-1:0] addr_next [NP];
  logic [ADDR_W-1:0] addr_q    [NP];
  logic [ADDR_W-1:0] base_q    [NP];

  // Per-port registers
  logic              standby_q [NP];
  logic [1:0]        wake_q    [NP];
  logic [NB-1:0]     we_q      [NP];
  logic [DATA_W-1:0] wdata_q   [NP];
  logic [NB-1:0]     drv_pl_q  [NP];
  logic [DATA_W-1:0] out_q     [NP];
  logic [NB-1:0]     drive_q   [NP];

  // Identical logic for every port
  for (genvar p = 0; p < NP; p++) begin : g_port

    // Select decode and byte enables
    assign sel_raw[p]  = !chip_select_a_n[p] && chip_select_b[p];
    assign be_raw_n[p] = {upper_byte_enable_n[p], lower_byte_enable_n[p]};

    // Count selected cycles since the last deselect, saturating
    assign wake_d[p] = !sel_raw[p] ? dpr_pkg::WAKE_RESET :
                       (wake_q[p] == dpr_pkg::WAKE_CYCLES) ? wake_q[p] :
                       wake_q[p] + dpr_pkg::WAKE_STEP;

    // Byte drive wanted by the read captured at this edge
    // Only a port selected at this edge and the one before may drive
    assign drv_ft_d[p] = {NB{sel_raw[p] && read_not_write[p] &&
                             (wake_d[p] == dpr_pkg::WAKE_CYCLES)}} & ~be_raw_n[p];

    // Address counter
    dpr_addr_ctr #(
      .ADDR_W (ADDR_W)
    ) u_ctr (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .ext_addr  (address[p]),
      .load_n    (address_load_strobe_n[p]),
      .advance_n (counter_advance_n[p]),
      .repeat_n  (counter_repeat_n[p]),
      .addr_next (addr_next[p]),
      .addr_q    (addr_q[p]),
      .base_q    (base_q[p])
    );

    // Reads start at the capture edge, writes land on the next one
    assign mem_re[p]    = sel_raw[p] && read_not_write[p];
    assign mem_raddr[p] = addr_next[p];
    assign mem_we[p]    = we_q[p];
    assign mem_waddr[p] = addr_q[p];
    assign mem_wdata[p] = wdata_q[p];

    // Input capture and select tracking
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        standby_q[p] <= 1'b1;
        wake_q[p]    <= dpr_pkg::WAKE_RESET;
        we_q[p]      <= '0;
        wdata_q[p]   <= '0;
      end else if (clk_en) begin
        standby_q[p] <= !sel_raw[p];
        wake_q[p]    <= wake_d[p];
        we_q[p]      <= {NB{sel_raw[p] && !read_not_write[p]}} & ~be_raw_n[p];
        wdata_q[p]   <= data_in[p];
      end
    end

    // Output stages: flow-through shows the array register, pipelined one more
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        drv_pl_q[p] <= '0;
        out_q[p]    <= '0;
        drive_q[p]  <= '0;
      end else if (clk_en) begin
        drv_pl_q[p] <= drv_ft_d[p];
        out_q[p]    <= mem_rdata[p];
        drive_q[p]  <= output_latency_select[p] ? drv_pl_q[p] : drv_ft_d[p];
      end
    end

    // Output enable acts on the drivers without waiting for a clock
    assign data_oe_n[p]    = ~(drive_q[p] & {NB{!output_enable_n[p]}});
    // Static latency select picks the array register or the extra stage
    assign data_out[p]     = output_latency_select[p] ? out_q[p] : mem_rdata[p];
    assign port_standby[p] = standby_q[p];

    // Deselect puts the port in standby on the next edge
    property p_sleep;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      !sel_raw[p] |=> standby_q[p] && (we_q[p] == '0);
    endproperty
    a_sleep: assert property (p_sleep) else $error("port not in standby after deselect");

    // No drive from the deselect edge until the second selected read may show
    property p_wake;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      !sel_raw[p] |=> (output_latency_select[p] || drive_q[p] == '0)
                      ##1 (drive_q[p] == '0)
                      ##1 (!output_latency_select[p] || drive_q[p] == '0);
    endproperty
    a_wake: assert property (p_wake) else $error("outputs woke too early");

    // Load takes the external address
    property p_load;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      !address_load_strobe_n[p] |=> addr_q[p] == $past(address[p]) && base_q[p] == addr_q[p];
    endproperty
    a_load: assert property (p_load) else $error("address not loaded");

    // Hold keeps the address and so the read word
    property p_hold;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (address_load_strobe_n[p] && counter_advance_n[p] && counter_repeat_n[p])
        |=> $stable(addr_q[p]);
    endproperty
    a_hold: assert property (p_hold) else $error("address moved while held");

    // Advance steps the address by one
    property p_adv;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (address_load_strobe_n[p] && counter_repeat_n[p] && !counter_advance_n[p])
        |=> addr_q[p] == ADDR_W'($past(addr_q[p]) + ADDR_W'(1));
    endproperty
    a_adv: assert property (p_adv) else $error("address did not advance by one");

    // Repeat returns to the last loaded address
    property p_repeat;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (address_load_strobe_n[p] && !counter_repeat_n[p]) |=> addr_q[p] == $past(base_q[p]);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat missed base address");

    // Lower byte written exactly when selected, writing and enabled
    property p_write;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      1'b1 |=> we_q[p][LB] == $past(sel_raw[p] && !read_not_write[p] &&
                                    !lower_byte_enable_n[p]);
    endproperty
    a_write: assert property (p_write) else $error("wrong lower byte write");

    // Flow-through drives an awake read right after its capture edge
    property p_flow;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (!output_latency_select[p] && sel_raw[p] && read_not_write[p] &&
       (wake_q[p] != dpr_pkg::WAKE_RESET) && !lower_byte_enable_n[p]) |=> drive_q[p][LB];
    endproperty
    a_flow: assert property (p_flow) else $error("flow-through drive late");

    // Pipelined shows the array word one edge after the array register
    property p_pipe;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      output_latency_select[p] |=> data_out[p] === $past(mem_rdata[p]);
    endproperty
    a_pipe: assert property (p_pipe) else $error("pipelined data wrong");

    // Pipelined drives the same read one edge later than flow-through
    property p_pipe_drive;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (output_latency_select[p] && sel_raw[p] && read_not_write[p] &&
       (wake_q[p] != dpr_pkg::WAKE_RESET) && !lower_byte_enable_n[p]) |-> ##2 drive_q[p][LB];
    endproperty
    a_pipe_drive: assert property (p_pipe_drive) else $error("pipelined drive wrong");

    // In flow-through, a disabled upper byte is never driven by the resulting read
    property p_byte_off;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (!output_latency_select[p] && sel_raw[p] && read_not_write[p] && upper_byte_enable_n[p])
        |=> !drive_q[p][UB];
    endproperty
    a_byte_off: assert property (p_byte_off) else $error("disabled byte driven");

    // A selected edge leaves standby at once
    property p_awake;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      sel_raw[p] |=> !standby_q[p];
    endproperty
    a_awake: assert property (p_awake) else $error("port stuck in standby");

    // A read never writes the array
    property p_read_only;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      read_not_write[p] |=> we_q[p] == '0;
    endproperty
    a_read_only: assert property (p_read_only) else $error("read wrote a byte");

    // The repeat base moves only on a load
    property p_base_keep;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      address_load_strobe_n[p] |=> $stable(base_q[p]);
    endproperty
    a_base_keep: assert property (p_base_keep) else $error("repeat base moved");

    // A reload accesses the base in the same cycle, no idle edge
    property p_reload;
      @(posedge ref_clk) disable iff (rst || !clk_en)
      (address_load_strobe_n[p] && !counter_repeat_n[p]) |-> mem_raddr[p] == base_q[p];
    endproperty
    a_reload: assert property (p_reload) else $error("reload access not at base");

    // Main scenarios
    c_read_drive: cover property (@(posedge ref_clk) disable iff (rst)
      drive_q[p] == '1 && !output_enable_n[p]);
    c_repeat: cover property (@(posedge ref_clk) disable iff (rst)
      address_load_strobe_n[p] && !counter_repeat_n[p] && read_not_write[p]);
    c_rewake: cover property (@(posedge ref_clk) disable iff (rst)
      !sel_raw[p] ##1 sel_raw[p] [*3]);
    c_pipe_read: cover property (@(posedge ref_clk) disable iff (rst)
      output_latency_select[p] && drive_q[p] != '0);
    c_write: cover property (@(posedge ref_clk) disable iff (rst)
      we_q[p] != '0);
  end

  // Shared storage array
  dpr_mem #(
    .ADDR_W    (ADDR_W),
    .DATA_W    (DATA_W),
    .BYTE_W    (BW),
    .NUM_BYTES (NB),
    .NUM_PORTS (NP)
  ) u_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_en   (mem_re),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

endmodule : dpr_port_top

`default_nettype wire

/* File: testbench/dpr_host_model.sv */
// Host controller model that drives both ports of the RAM port logic.
// Assumes it is the only driver of the port inputs; one op or idle call is one cycle, a wr call two.
`timescale 1ns/10ps
`default_nettype none

module dpr_host_model (
  input  wire logic             ref_clk,
  output var  logic [1:0]       chip_select_a_n,
  output var  logic [1:0]       chip_select_b,
  output var  logic [1:0]       address_load_strobe_n,
  output var  logic [1:0]       counter_advance_n,
  output var  logic [1:0]       counter_repeat_n,
  output var  logic [1:0]       upper_byte_enable_n,
  output var  logic [1:0]       lower_byte_enable_n,
  output var  logic [1:0]       read_not_write,
  output var  logic [1:0][17:0] address,
  output var  logic [1:0][17:0] data_in
);
  // Selected idle reads with both bytes off until told otherwise
  initial begin
    chip_select_a_n       = 2'h0;
    chip_select_b         = 2'h3;
    address_load_strobe_n = 2'h0;
    counter_advance_n     = 2'h3;
    counter_repeat_n      = 2'h3;
    upper_byte_enable_n   = 2'h3;
    lower_byte_enable_n   = 2'h3;
    read_not_write        = 2'h3;
    address               = '0;
    data_in               = '0;
  end

  // One cycle of one port: set after the falling edge, held a full cycle
  task automatic op(input int p, input logic [1:0] cs, input logic rd, input logic [2:0] ctl,
                    input logic [1:0] ben, input logic [17:0] a, input logic [17:0] d);
    @(negedge ref_clk);
    {chip_select_a_n[p], chip_select_b[p]} = cs;
    read_not_write[p] = rd;
    {address_load_strobe_n[p], counter_advance_n[p], counter_repeat_n[p]} = ctl;
    {upper_byte_enable_n[p], lower_byte_enable_n[p]} = ben;
    address[p] = a;
    data_in[p] = rd ? ~data_in[p] : d; // Bus not written carries no stale word
  endtask : op

  // Selected read with both bytes off and the counter held
  task automatic idle(input int p);
    op(p, 2'h1, 1'b1, 3'h7, 2'h3, address[p], 18'h0);
  endtask : idle

  // Write then idle once, so no read reaches the word before it lands
  task automatic wr(input int p, input logic [17:0] a, input logic [17:0] d,
                    input logic [1:0] ben);
    op(p, 2'h1, 1'b0, 3'h3, ben, a, d);
    idle(p);
  endtask : wr
endmodule : dpr_host_model

`default_nettype wire

/* File: testbench/dpr_port_top_bench.sv */
// Self-checking bench for the RAM port logic, host model on both ports.
// Assumes port 0 runs flow-through and port 1 pipelined for the whole run.
`timescale 1ns/10ps
`default_nettype none

module dpr_port_top_bench;
  localparam logic [1:0] SEL = 2'h1, DSA = 2'h3, DSB = 2'h0, ALL = 2'h0, LOW = 2'h2;
  localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HLD = 3'h7, RPT = 3'h6;
  logic             ref_clk               = 1'b0;
  logic             rst                   = 1'b1;
  logic             clk_en                = 1'b1;
  logic [1:0]       output_enable_n       = 2'h0;
  logic [1:0]       output_latency_select = 2'h2;
  logic [1:0]       chip_select_a_n, chip_select_b, address_load_strobe_n, counter_advance_n;
  logic [1:0]       counter_repeat_n, upper_byte_enable_n, lower_byte_enable_n;
  logic [1:0]       read_not_write, port_standby;
  logic [1:0][17:0] address, data_in, data_out;
  logic [1:0][1:0]  data_oe_n;
  int               n_fail = 0;
  int               n_checks = 0;
  int               cyc = 0;

  dpr_host_model u_dpr_host_model (.ref_clk, .chip_select_a_n, .chip_select_b,
    .address_load_strobe_n, .counter_advance_n, .counter_repeat_n, .upper_byte_enable_n,
    .lower_byte_enable_n, .read_not_write, .address, .data_in);

  dpr_port_top u_dpr_port_top (.ref_clk, .rst, .clk_en, .chip_select_a_n, .chip_select_b,
    .address_load_strobe_n, .counter_advance_n, .counter_repeat_n, .upper_byte_enable_n,
    .lower_byte_enable_n, .read_not_write, .output_enable_n, .output_latency_select,
    .address, .data_in, .data_out, .data_oe_n, .port_standby);

  // Clock and a cycle ceiling against hangs
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Read a word and look at it once the port's latency has passed
  task automatic rd(input int p, input logic [17:0] a, input logic [1:0] ben,
                    input logic [17:0] exp);
    logic [17:0] m;
    m = {{9{~ben[1]}}, {9{~ben[0]}}};
    u_dpr_host_model.op(p, SEL, 1'b1, LD, ben, a, 18'h0);
    u_dpr_host_model.idle(p);
    if (p == 1) begin
      chk(18'(data_oe_n[1]), 18'h3, "early drive");
      u_dpr_host_model.idle(p);
    end
    chk(data_out[p] & m, exp & m, "read data");
    chk(18'(data_oe_n[p]), 18'(ben), "byte drive");
  endtask : rd

  task automatic t_bytes();
    u_dpr_host_model.wr(0, 18'h00010, 18'h2a5a5, ALL);
    u_dpr_host_model.wr(0, 18'h00010, 18'h1c3c3, LOW);
    rd(0, 18'h00010, ALL, 18'h2a5c3);
    rd(0, 18'h00010, LOW, 18'h2a5c3);
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_cross();
    u_dpr_host_model.wr(0, 18'h3fffe, 18'h3f00f, ALL);
    rd(1, 18'h3fffe, ALL, 18'h3f00f);
    $display("test cross done");
  endtask : t_cross

  task automatic t_ctr();
    u_dpr_host_model.wr(0, 18'h00100, 18'h11111, ALL);
    u_dpr_host_model.wr(0, 18'h00101, 18'h22222, ALL);
    u_dpr_host_model.op(0, SEL, 1'b1, LD, ALL, 18'h00100, 18'h0);
    u_dpr_host_model.op(0, SEL, 1'b1, ADV, ALL, 18'h3ffff, 18'h0);
    chk(data_out[0], 18'h11111, "load");
    u_dpr_host_model.op(0, SEL, 1'b1, HLD, ALL, 18'h3ffff, 18'h0);
    chk(data_out[0], 18'h22222, "advance");
    u_dpr_host_model.op(0, SEL, 1'b1, RPT, ALL, 18'h3ffff, 18'h0);
    chk(data_out[0], 18'h22222, "hold");
    u_dpr_host_model.op(0, SEL, 1'b0, ADV, ALL, 18'h3ffff, 18'h33333);
    chk(data_out[0], 18'h11111, "repeat");
    u_dpr_host_model.op(0, SEL, 1'b0, RPT, ALL, 18'h3ffff, 18'h44444);
    u_dpr_host_model.idle(0);
    rd(0, 18'h00101, ALL, 18'h33333);
    rd(0, 18'h00100, ALL, 18'h44444);
    $display("test counter done");
  endtask : t_ctr

  // Deselect by each chip select in turn, with a write that must be refused
  task automatic t_wake();
    for (int i = 0; i < 2; i++) begin
      u_dpr_host_model.op(0, (i == 0) ? DSA : DSB, 1'b0, LD, ALL, 18'h00010, 18'h3ffff);
      u_dpr_host_model.op(0, SEL, 1'b1, LD, ALL, 18'h00010, 18'h0);
      chk(18'(port_standby[0]), 18'h1, "standby");
      chk(18'(data_oe_n[0]), 18'h3, "deselect drive");
      u_dpr_host_model.op(0, SEL, 1'b1, LD, ALL, 18'h00010, 18'h0);
      chk(18'(port_standby[0]), 18'h0, "awake");
      chk(18'(data_oe_n[0]), 18'h3, "first read drive");
      u_dpr_host_model.idle(0);
      chk(18'(data_oe_n[0]), 18'h0, "second read drive");
      chk(data_out[0], 18'h2a5c3, "refused write");
    end
    $display("test wake done");
  endtask : t_wake

  task automatic t_oe();
    u_dpr_host_model.op(0, SEL, 1'b1, LD, ALL, 18'h00010, 18'h0);
    u_dpr_host_model.op(0, SEL, 1'b1, HLD, ALL, 18'h00010, 18'h0);
    #0.5 output_enable_n[0] = 1'b1;
    #0.5 chk(18'(data_oe_n[0]), 18'h3, "enable off");
    output_enable_n[0] = 1'b0;
    #0.5 chk(18'(data_oe_n[0]), 18'h0, "enable on");
    $display("test enable done");
  endtask : t_oe

  // Reset, wake both ports, run the tests
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) begin
      u_dpr_host_model.idle(0);
      u_dpr_host_model.idle(1);
    end
    t_bytes();
    t_cross();
    t_ctr();
    t_wake();
    t_oe();
    end_of_test();
  end
endmodule : dpr_port_top_bench

`default_nettype wire
